// ### cbcs_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// behavioural memory on the expanded bus, answers within the same cycle
module cbcs_mem_model (
    input wire logic clk_sys_i,
    input wire logic [15:0] addr_i,
    input wire logic rnw_i,
    output logic [7:0] data_o
);
    logic [7:0] last_q = 8'h00;

    // content is a hash of the address, so every location can be predicted
    function automatic logic [7:0] pattern(input logic [15:0] a);
        pattern = a[15:8] ^ {a[6:0], a[7]} ^ 8'h5a;
    endfunction : pattern

    // released bus while the core writes: inverse of last value, never a stale copy
    always_comb begin
        data_o = rnw_i ? pattern(addr_i) : ~last_q;
    end

    // remember what stood on the bus
    always_ff @(posedge clk_sys_i) begin
        last_q <= data_o;
    end
endmodule : cbcs_mem_model
`default_nettype wire

// ### cbcs_pkg.sv
// Summary of operation
// RULE_01: extended jump: opcode, target high at pc+1, low at pc+2, all reads, 3 cycles.
// RULE_02: extended 8-bit reads: opcode, address high, address low, operand read; 4 cycles.
// RULE_03: extended accumulator store: fourth cycle writes accumulator to destination address.
// RULE_04: extended 16-bit loads: high byte at address, low at address+1; 5 cycles.
// RULE_05: extended 16-bit stores: write high at address, low at address+1; 5 cycles.
// RULE_06: read-modify-write: read, dummy, write back to same address; 6 cycles.
// RULE_07: test operand never writes; sixth cycle is a dummy at all ones.
// RULE_08: extended 16-bit compare/add/subtract: read high, low, then dummy; 6 cycles.
// RULE_09: extended call: read subroutine start, write return low at sp, high at sp-1.
// RULE_10: every dummy cycle reads address all ones, data discarded.
// RULE_11: indexed: offset in cycle 2, dummy in 3; jump 3 cycles, 8-bit 4.
// RULE_12: indexed 16-bit loads and stores: high at index+offset, low at plus one.
// RULE_13: indexed read-modify-write and 16-bit arithmetic take 6 cycles with dummies.
// RULE_14: indexed call: offset, dummy, read target, return low at sp, high sp-1.
// RULE_15: on-chip reads are not echoed on the external bus except in mode 0.
// RULE_16: all bus address arithmetic is 16 bits and wraps.
`default_nettype none
package cbcs_pkg;
    localparam logic [15:0] DUMMY_ADDR = 16'hffff;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;
    localparam logic [15:0] STEP_THREE = 16'h0003;
    localparam logic [2:0] LEN_JUMP = 3'h3;
    localparam logic [2:0] LEN_SHORT = 3'h4;
    localparam logic [2:0] LEN_PAIR = 3'h5;
    localparam logic [2:0] LEN_LONG = 3'h6;

    // instruction groups that share one bus pattern
    typedef enum logic [3:0] {
        CLS_JUMP, CLS_READ8, CLS_STORE_ACC, CLS_LOAD16, CLS_STORE16,
        CLS_RMW, CLS_TEST, CLS_ARITH16, CLS_CALL
    } cbcs_class_t;

    // bus cycle of the current instruction, cycle 1 is opcode fetch
    typedef enum logic [2:0] {
        CY_IDLE, CY_1, CY_2, CY_3, CY_4, CY_5, CY_6
    } cbcs_cyc_t;

    // total cycles per group, same for extended and indexed
    function automatic logic [2:0] cbcs_len(input cbcs_class_t cls);
        unique case (cls)
            CLS_JUMP: cbcs_len = LEN_JUMP;
            CLS_READ8, CLS_STORE_ACC: cbcs_len = LEN_SHORT;
            CLS_LOAD16, CLS_STORE16: cbcs_len = LEN_PAIR;
            default: cbcs_len = LEN_LONG;
        endcase
    endfunction : cbcs_len
endpackage : cbcs_pkg
`default_nettype wire

// ### cbcs_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module cbcs_sequencer (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire cbcs_pkg::cbcs_class_t class_i,
    input wire logic indexed_i,
    input wire logic [15:0] pc_i,
    input wire logic [15:0] index_i,
    input wire logic [15:0] sp_i,
    input wire logic [7:0] acc_i,
    input wire logic [15:0] reg16_i,
    input wire logic [7:0] new_data_i,
    input wire logic mode0_i,
    input wire logic onchip_i,
    input wire logic [7:0] int_data_i,
    input wire logic [7:0] data_i,
    output logic ready_o,
    output logic busy_o,
    output logic done_o,
    output logic [15:0] addr_o,
    output logic rnw_o,
    output logic dummy_o,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic [15:0] operand_o,
    output logic [15:0] target_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    cbcs_pkg::cbcs_cyc_t cyc_q, cyc_d;
    cbcs_pkg::cbcs_class_t cls_q, cls_d;
    logic idx_q, idx_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] xr_q, xr_d;
    logic [15:0] sp_q, sp_d;
    logic [7:0] acc_q, acc_d;
    logic [15:0] reg_q, reg_d;
    logic [7:0] hi_q, hi_d;
    logic [7:0] lo_q, lo_d;
    logic [15:0] ea_q, ea_d;
    logic [15:0] opnd_q, opnd_d;
    logic [15:0] addr_q, addr_d;
    logic rnw_q, rnw_d;
    logic dummy_q, dummy_d;
    logic [7:0] wdata_q, wdata_d;
    logic [15:0] ret_d;
    logic busy;
    logic last;
    logic take;
    logic wide;

    // busy and end-of-instruction decode
    assign busy = (cyc_q != cbcs_pkg::CY_IDLE);
    assign last = busy && (3'(cyc_q) == cbcs_pkg::cbcs_len(cls_q));
    // back to back is allowed: a new start is taken in the last cycle
    assign take = start_i && (!busy || last);
    assign wide = (cls_q == cbcs_pkg::CLS_LOAD16) || (cls_q == cbcs_pkg::CLS_ARITH16);

    ////////////////////////////////////////////////////////////////////////////
    // sequence and operand capture

    always_comb begin
        cyc_d = cyc_q;
        cls_d = cls_q;
        idx_d = idx_q;
        pc_d = pc_q;
        xr_d = xr_q;
        sp_d = sp_q;
        acc_d = acc_q;
        reg_d = reg_q;
        hi_d = hi_q;
        lo_d = lo_q;
        opnd_d = opnd_q;
        // capture bytes read in the cycle now ending
        unique case (cyc_q)
            cbcs_pkg::CY_2: begin
                hi_d = data_i;
            end
            cbcs_pkg::CY_3: begin
                if (!idx_q) begin
                    lo_d = data_i;
                end
            end
            cbcs_pkg::CY_4: begin
                if (wide) begin
                    opnd_d[15:8] = data_i;
                end else if (rnw_q) begin
                    opnd_d = {8'h00, data_i};
                end
            end
            cbcs_pkg::CY_5: begin
                if (wide) begin
                    opnd_d[7:0] = data_i;
                end
            end
            default: begin
            end
        endcase
        if (take) begin
            cyc_d = cbcs_pkg::CY_1;
            cls_d = class_i;
            idx_d = indexed_i;
            pc_d = pc_i;
            xr_d = index_i;
            sp_d = sp_i;
            acc_d = acc_i;
            reg_d = reg16_i;
        end else if (last) begin
            cyc_d = cbcs_pkg::CY_IDLE;
        end else if (busy) begin
            cyc_d = cbcs_pkg::cbcs_cyc_t'(3'(cyc_q) + 3'h1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cyc_q <= cbcs_pkg::CY_IDLE;
            cls_q <= cbcs_pkg::CLS_JUMP;
            idx_q <= 1'b0;
            pc_q <= cbcs_pkg::ADDR_RST;
            xr_q <= cbcs_pkg::ADDR_RST;
            sp_q <= cbcs_pkg::ADDR_RST;
            acc_q <= cbcs_pkg::BYTE_RST;
            reg_q <= cbcs_pkg::ADDR_RST;
            hi_q <= cbcs_pkg::BYTE_RST;
            lo_q <= cbcs_pkg::BYTE_RST;
            opnd_q <= cbcs_pkg::ADDR_RST;
        end else begin
            cyc_q <= cyc_d;
            cls_q <= cls_d;
            idx_q <= idx_d;
            pc_q <= pc_d;
            xr_q <= xr_d;
            sp_q <= sp_d;
            acc_q <= acc_d;
            reg_q <= reg_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            opnd_q <= opnd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus pattern for the next cycle, registered so pins are glitch free

    always_comb begin
        // unsigned offset, wraps at 64k; held mode so a new start leaves target alone
        // RULE_16 wrapping address sums
        ea_d = idx_q ? 16'(xr_q + {8'h00, hi_d}) : {hi_d, lo_d};
        // return point is the following instruction
        ret_d = 16'(pc_d + (idx_d ? cbcs_pkg::STEP_TWO : cbcs_pkg::STEP_THREE));
        addr_d = cbcs_pkg::ADDR_RST;
        rnw_d = 1'b1;
        dummy_d = 1'b0;
        wdata_d = cbcs_pkg::BYTE_RST;
        unique case (cyc_d)
            cbcs_pkg::CY_IDLE: begin
                addr_d = cbcs_pkg::ADDR_RST;
            end
            // RULE_01 opcode and address fetch
            cbcs_pkg::CY_1: begin
                addr_d = pc_d;
            end
            cbcs_pkg::CY_2: begin
                addr_d = 16'(pc_d + cbcs_pkg::STEP_ONE);
            end
            // RULE_11 indexed dummy cycle
            cbcs_pkg::CY_3: begin
                if (idx_d) begin
                    dummy_d = 1'b1;
                end else begin
                    addr_d = 16'(pc_d + cbcs_pkg::STEP_TWO);
                end
            end
            // RULE_02 operand access at address
            cbcs_pkg::CY_4: begin
                addr_d = ea_d;
                if (cls_d == cbcs_pkg::CLS_STORE_ACC) begin
                    // RULE_03 accumulator write
                    rnw_d = 1'b0;
                    wdata_d = acc_d;
                end else if (cls_d == cbcs_pkg::CLS_STORE16) begin
                    // RULE_05 high byte first
                    rnw_d = 1'b0;
                    wdata_d = reg_d[15:8];
                end
            end
            cbcs_pkg::CY_5: begin
                if (cls_d == cbcs_pkg::CLS_CALL) begin
                    // RULE_09 return low byte at sp
                    addr_d = sp_d;
                    rnw_d = 1'b0;
                    wdata_d = ret_d[7:0];
                end else if (cls_d == cbcs_pkg::CLS_RMW || cls_d == cbcs_pkg::CLS_TEST) begin
                    // RULE_06 RULE_13 modify gap
                    dummy_d = 1'b1;
                end else begin
                    // RULE_04 low byte at address plus one
                    // RULE_12 indexed pair
                    addr_d = 16'(ea_d + cbcs_pkg::STEP_ONE);
                    if (cls_d == cbcs_pkg::CLS_STORE16) begin
                        rnw_d = 1'b0;
                        wdata_d = reg_d[7:0];
                    end
                end
            end
            cbcs_pkg::CY_6: begin
                if (cls_d == cbcs_pkg::CLS_CALL) begin
                    // RULE_14 return high byte at sp minus one
                    addr_d = 16'(sp_d - cbcs_pkg::STEP_ONE);
                    rnw_d = 1'b0;
                    wdata_d = ret_d[15:8];
                end else if (cls_d == cbcs_pkg::CLS_RMW) begin
                    // new value sampled as cycle 5 ends
                    addr_d = ea_d;
                    rnw_d = 1'b0;
                    wdata_d = new_data_i;
                end else begin
                    // RULE_07 test skips the write
                    // RULE_08 trailing dummy
                    dummy_d = 1'b1;
                end
            end
        endcase
        // RULE_10 dummy reads hit all ones
        if (dummy_d) begin
            addr_d = cbcs_pkg::DUMMY_ADDR;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ea_q <= cbcs_pkg::ADDR_RST;
            addr_q <= cbcs_pkg::ADDR_RST;
            rnw_q <= 1'b1;
            dummy_q <= 1'b0;
            wdata_q <= cbcs_pkg::BYTE_RST;
        end else begin
            ea_q <= ea_d;
            addr_q <= addr_d;
            rnw_q <= rnw_d;
            dummy_q <= dummy_d;
            wdata_q <= wdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins

    assign ready_o = !busy || last;
    assign busy_o = busy;
    assign done_o = last;
    assign addr_o = addr_q;
    assign rnw_o = rnw_q;
    assign dummy_o = dummy_q;
    assign operand_o = opnd_q;
    assign target_o = ea_q;
    // RULE_15 on-chip reads echo only in mode 0
    assign data_oe_o = busy && (!rnw_q || (onchip_i && mode0_i && !dummy_q));
    // write data is registered; the echo path is a limitation, it is combinational
    assign data_o = rnw_q ? int_data_i : wdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_read_at_plus_one;
        rnw_o ##1 (rnw_o && addr_o == 16'($past(addr_o) + 16'h0001));
    endsequence

    sequence s_dummy;
        rnw_o && dummy_o && addr_o == 16'hffff;
    endsequence

    ext_jump_a: assert property ( // RULE_01
        (cyc_q == cbcs_pkg::CY_1 && cls_q == cbcs_pkg::CLS_JUMP && !idx_q)
        |-> (rnw_o && addr_o == pc_q) ##1 s_read_at_plus_one ##0 done_o)
        else $error("extended jump sequence wrong");

    read8_len_a: assert property ( // RULE_02
        (cyc_q == cbcs_pkg::CY_1 && cls_q == cbcs_pkg::CLS_READ8)
        |-> !done_o [*3] ##1 (rnw_o && done_o && addr_o == ea_q))
        else $error("8-bit read length wrong");

    acc_store_a: assert property ( // RULE_03
        (cyc_q == cbcs_pkg::CY_4 && cls_q == cbcs_pkg::CLS_STORE_ACC)
        |-> !rnw_o && data_oe_o && data_o == acc_q && done_o)
        else $error("accumulator store wrong");

    load_pair_a: assert property ( // RULE_04
        (cyc_q == cbcs_pkg::CY_4 && cls_q == cbcs_pkg::CLS_LOAD16)
        |-> s_read_at_plus_one ##0 done_o)
        else $error("16-bit load pair wrong");

    store_pair_a: assert property ( // RULE_05
        (cyc_q == cbcs_pkg::CY_4 && cls_q == cbcs_pkg::CLS_STORE16)
        |-> (!rnw_o && data_o == reg_q[15:8])
        ##1 (!rnw_o && data_o == reg_q[7:0] && done_o
             && addr_o == 16'($past(addr_o) + 16'h0001)))
        else $error("16-bit store pair wrong");

    rmw_order_a: assert property ( // RULE_06
        (cyc_q == cbcs_pkg::CY_4 && cls_q == cbcs_pkg::CLS_RMW)
        |-> rnw_o ##1 s_dummy ##1 (!rnw_o && done_o && addr_o == $past(addr_o, 2)))
        else $error("read-modify-write order wrong");

    test_nowrite_a: assert property ( // RULE_07
        (cls_q == cbcs_pkg::CLS_TEST && busy) |-> rnw_o)
        else $error("test operand wrote");

    arith_tail_a: assert property ( // RULE_08
        (cyc_q == cbcs_pkg::CY_4 && cls_q == cbcs_pkg::CLS_ARITH16)
        |-> s_read_at_plus_one ##1 s_dummy ##0 done_o)
        else $error("16-bit arithmetic tail wrong");

    call_stack_a: assert property ( // RULE_09
        (cyc_q == cbcs_pkg::CY_5 && cls_q == cbcs_pkg::CLS_CALL)
        |-> (!rnw_o && addr_o == sp_q)
        ##1 (!rnw_o && done_o && addr_o == 16'(sp_q - 16'h0001)))
        else $error("call stacking wrong");

    dummy_addr_a: assert property ( // RULE_10
        dummy_o |-> rnw_o && addr_o == 16'hffff && !data_oe_o)
        else $error("dummy cycle not at all ones");

    idx_gap_a: assert property ( // RULE_11
        (cyc_q == cbcs_pkg::CY_3 && idx_q) |-> s_dummy)
        else $error("indexed dummy missing");

    onchip_quiet_a: assert property ( // RULE_15
        (rnw_o && !mode0_i) |-> !data_oe_o)
        else $error("read echoed outside mode 0");

endmodule : cbcs_sequencer
`default_nettype wire

// ### cpu_bus_cycle_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_cycle_sequencer_tb_top;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic start_i = 1'b0;
    cbcs_pkg::cbcs_class_t class_i = cbcs_pkg::CLS_JUMP;
    logic indexed_i = 1'b0;
    logic [15:0] pc_i = 16'h0000;
    logic [15:0] index_i = 16'h0000;
    logic [15:0] sp_i = 16'h0000;
    logic [7:0] acc_i = 8'h00;
    logic [15:0] reg16_i = 16'h0000;
    logic [7:0] new_data_i = 8'h00;
    logic mode0_i = 1'b0;
    logic onchip_i = 1'b0;
    logic [7:0] int_data_i = 8'h00;
    logic [7:0] data_i;
    logic ready_o, busy_o, done_o, rnw_o, dummy_o, data_oe_o;
    logic [15:0] addr_o, operand_o, target_o, ea, ret;
    logic [7:0] data_o;
    logic [25:0] e;
    int err_count = 0;
    int check_count = 0;
    int seed = 32'h639cd92c;

    always #2.5 clk_sys_i = ~clk_sys_i;

    cbcs_sequencer u_cbcs_sequencer (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .start_i(start_i), .class_i(class_i), .indexed_i(indexed_i), .pc_i(pc_i),
        .index_i(index_i), .sp_i(sp_i), .acc_i(acc_i), .reg16_i(reg16_i),
        .new_data_i(new_data_i), .mode0_i(mode0_i), .onchip_i(onchip_i),
        .int_data_i(int_data_i), .data_i(data_i), .ready_o(ready_o), .busy_o(busy_o),
        .done_o(done_o), .addr_o(addr_o), .rnw_o(rnw_o), .dummy_o(dummy_o),
        .data_o(data_o), .data_oe_o(data_oe_o), .operand_o(operand_o),
        .target_o(target_o));

    cbcs_mem_model u_cbcs_mem_model (.clk_sys_i(clk_sys_i), .addr_i(addr_o),
        .rnw_i(rnw_o), .data_o(data_i));

    ////////////////////////////////////////////////////////////////////////////
    // compare tasks, one per kind of result
    task automatic chk_bus(input logic [25:0] g, input logic [25:0] x);
        check_count++;
        if (g !== x) begin
            err_count++;
            $display("wrong value at %0t: bus cycle got %h exp %h", $time, g, x);
        end
    endtask : chk_bus
    task automatic chk_word(input logic [15:0] g, input logic [15:0] x);
        check_count++;
        if (g !== x) begin
            err_count++;
            $display("wrong value at %0t: result got %h exp %h", $time, g, x);
        end
    endtask : chk_word
    task automatic chk_bit(input logic g, input logic x);
        check_count++;
        if (g !== x) begin
            err_count++;
            $display("wrong value at %0t: flag got %b exp %b", $time, g, x);
        end
    endtask : chk_bit

    // expected length of each group, same in both modes
    function automatic int exp_len(input cbcs_pkg::cbcs_class_t c);
        case (c)
            cbcs_pkg::CLS_JUMP: return 3;
            cbcs_pkg::CLS_READ8, cbcs_pkg::CLS_STORE_ACC: return 4;
            cbcs_pkg::CLS_LOAD16, cbcs_pkg::CLS_STORE16: return 5;
            default: return 6;
        endcase
    endfunction : exp_len

    // expected {rnw, dummy, address, write data} of bus cycle c
    function automatic logic [25:0] exp_cyc(input int c);
        logic [15:0] a;
        logic r;
        logic d;
        logic [7:0] w;
        a = ea;
        r = 1'b1;
        d = 1'b0;
        w = 8'h00;
        case (c)
            1: a = pc_i;
            2: a = pc_i + 16'h0001;
            3: if (indexed_i) d = 1'b1; else a = pc_i + 16'h0002;
            4: if (class_i == cbcs_pkg::CLS_STORE_ACC) {r, w} = {1'b0, acc_i};
               else if (class_i == cbcs_pkg::CLS_STORE16) {r, w} = {1'b0, reg16_i[15:8]};
            5: case (class_i)
                cbcs_pkg::CLS_LOAD16, cbcs_pkg::CLS_ARITH16: a = ea + 16'h0001;
                cbcs_pkg::CLS_STORE16: {a, r, w} = {ea + 16'h0001, 1'b0, reg16_i[7:0]};
                cbcs_pkg::CLS_CALL: {a, r, w} = {sp_i, 1'b0, ret[7:0]};
                default: d = 1'b1;
            endcase
            default: case (class_i)
                cbcs_pkg::CLS_RMW: {r, w} = {1'b0, new_data_i};
                cbcs_pkg::CLS_CALL: {a, r, w} = {sp_i - 16'h0001, 1'b0, ret[15:8]};
                default: d = 1'b1;
            endcase
        endcase
        if (d) a = 16'hffff;
        return {r, d, a, w};
    endfunction : exp_cyc

    // one instruction; corner values make pc+2, the return point, sp-1 and indexed ea+1 wrap
    task automatic run_one(input cbcs_pkg::cbcs_class_t c, input logic m, input logic k);
        int n;
        n = exp_len(c);
        class_i = c;
        indexed_i = m;
        pc_i = k ? 16'hfffe : 16'($random(seed));
        index_i = k ? 16'hffa5 : 16'($random(seed));
        sp_i = k ? 16'h0000 : 16'($random(seed));
        acc_i = 8'($random(seed));
        reg16_i = 16'($random(seed));
        new_data_i = 8'($random(seed));
        ea = m ? index_i + {8'h00, u_cbcs_mem_model.pattern(pc_i + 16'h0001)}
               : {u_cbcs_mem_model.pattern(pc_i + 16'h0001),
                  u_cbcs_mem_model.pattern(pc_i + 16'h0002)};
        ret = pc_i + (m ? 16'h0002 : 16'h0003);
        start_i = 1'b1;
        for (int i = 1; i <= n; i++) begin
            @(negedge clk_sys_i);
            e = exp_cyc(i);
            chk_bus({rnw_o, dummy_o, addr_o, rnw_o ? data_o ^ int_data_i : data_o}, e);
            chk_bit(done_o, i == n);
            chk_bit(ready_o && busy_o, i == n);
            chk_bit(data_oe_o, !e[25] || (mode0_i && onchip_i && !e[24]));
            // settled outputs are checked first, then inputs move on this falling edge
            if (i == 1) begin
                start_i = 1'b0;
            end
            {mode0_i, onchip_i, int_data_i} = 10'($random(seed));
        end
        if ($random(seed) & 1) begin
            @(negedge clk_sys_i);
            chk_bit(busy_o, 1'b0);
            chk_word(target_o, ea);
            if (c == cbcs_pkg::CLS_LOAD16 || c == cbcs_pkg::CLS_ARITH16) begin
                chk_word(operand_o, {u_cbcs_mem_model.pattern(ea),
                    u_cbcs_mem_model.pattern(ea + 16'h0001)});
            end else if (c == cbcs_pkg::CLS_READ8 || c == cbcs_pkg::CLS_RMW
                || c == cbcs_pkg::CLS_TEST || c == cbcs_pkg::CLS_CALL) begin
                chk_word(operand_o, {8'h00, u_cbcs_mem_model.pattern(ea)});
            end
        end
    endtask : run_one

    task final_report;
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // watchdog: a hang counts as a mismatch
    initial begin
        #400000;
        err_count++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    // every group in both modes at wrapping corners, then random traffic
    initial begin
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        @(negedge clk_sys_i);
        for (int k = 0; k < 18; k++) begin
            run_one(cbcs_pkg::cbcs_class_t'(k / 2), k[0], 1'b1);
        end
        for (int k = 0; k < 80; k++) begin
            run_one(cbcs_pkg::cbcs_class_t'($unsigned($random(seed)) % 9),
                1'($random(seed)), 1'b0);
        end
        final_report();
    end
endmodule : cpu_bus_cycle_sequencer_tb_top
`default_nettype wire
